// ### design/bus_register_consts.svh
// Constants for the twenty-bit bus register and its capture buffer
`ifndef BUS_REGISTER_CONSTS_SVH
`define BUS_REGISTER_CONSTS_SVH

// ============================================================
// Widths
`define WORD_W 20
`define SYNC_W 3
`define RST_PIPE_W 2

// ============================================================
// Reset values
`define WORD_CLR 20'h00000
`define SYNC_CLR 3'h0
`define RST_PIPE_CLR 2'h0
`define SYNC_SET 3'h7

// ============================================================
// Synchroniser stage positions
`define SYNC_MID 1
`define SYNC_LAST 2

`endif

// ### design/bus_register_pkg.sv
// Types shared by the bus register and its capture buffer
`include "bus_register_consts.svh"

package bus_register_pkg;

  // ============================================================
  // Stored and captured word
  typedef logic [`WORD_W-1:0] word_t;

  // ============================================================
  // Fill level of the two-entry buffer
  typedef enum logic [1:0] {
    BUF_EMPTY = 2'b00,
    BUF_ONE = 2'b01,
    BUF_TWO = 2'b10
  } buf_state_t;

endpackage

// ### design/two_entry_buf.sv
// Two-entry valid/ready buffer for captured words
`include "bus_register_consts.svh"

module two_entry_buf (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire bus_register_pkg::word_t in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output bus_register_pkg::word_t out_data_o
);

  // ============================================================
  // Storage
  bus_register_pkg::buf_state_t state_r; // Fill level
  bus_register_pkg::word_t head_r; // Oldest word
  bus_register_pkg::word_t tail_r; // Second word
  logic push; // Word accepted this cycle
  logic pop; // Word handed on this cycle

  // Handshakes from the fill level
  assign in_ready_o = (state_r != bus_register_pkg::BUF_TWO);
  assign out_valid_o = (state_r != bus_register_pkg::BUF_EMPTY);
  assign out_data_o = head_r;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Fill level tracking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= bus_register_pkg::BUF_EMPTY;
    end else begin
      case (state_r)
        bus_register_pkg::BUF_EMPTY: begin
          if (push) begin
            state_r <= bus_register_pkg::BUF_ONE;
          end
        end
        bus_register_pkg::BUF_ONE: begin
          if (push && !pop) begin
            state_r <= bus_register_pkg::BUF_TWO;
          end else if (pop && !push) begin
            state_r <= bus_register_pkg::BUF_EMPTY;
          end
        end
        bus_register_pkg::BUF_TWO: begin
          if (pop) begin
            state_r <= bus_register_pkg::BUF_ONE;
          end
        end
        default: begin
          state_r <= bus_register_pkg::BUF_EMPTY;
        end
      endcase
    end
  end

  // Word slots
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_r <= `WORD_CLR;
      tail_r <= `WORD_CLR;
    end else begin
      if (state_r == bus_register_pkg::BUF_TWO && pop) begin
        head_r <= tail_r;
      end else if (push && (state_r == bus_register_pkg::BUF_EMPTY || pop)) begin
        head_r <= in_data_i;
      end else if (push) begin
        tail_r <= in_data_i;
      end
    end
  end

endmodule

// ### design/bus_register.sv
// Twenty-bit edge-triggered bus register with clock and output enables
//
// Overview of operation
// - Twenty stored bits, outputs not inverted
// - Qualified rising clock edge loads data inputs
// - Clock enable high ignores edges, holds word
// - No rising edge means word stays held
// - Output enable high releases the twenty data outputs
// - Loading continues while outputs are released
// - Output enable low drives stored word
`include "bus_register_consts.svh"

module bus_register (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pins from the driving bus logic
  input wire logic pin_clk_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire bus_register_pkg::word_t data_in_i,
  // Pins towards the receiving bus logic
  output bus_register_pkg::word_t data_out_o,
  output logic data_out_oe_n_o,
  output logic word_known_o,
  // Stream of captured words
  output logic cap_valid_o,
  input wire logic cap_ready_i,
  output bus_register_pkg::word_t cap_data_o,
  output logic cap_space_o,
  output logic cap_overrun_o
);

  // ============================================================
  // Settling filter
  // Level moves only when the last two stages agree
  function automatic logic settle(input logic old, input logic mid, input logic last);
    settle = (mid == last) ? last : old;
  endfunction

  // ============================================================
  // Reset release
  logic [`RST_PIPE_W-1:0] rst_pipe_r; // Release pipeline
  logic rst_n; // Released reset for the whole block

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_r <= `RST_PIPE_CLR;
    end else begin
      rst_pipe_r <= {rst_pipe_r[`RST_PIPE_W-2:0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_r[`RST_PIPE_W-1];

  // ============================================================
  // Pin synchronisers
  logic [`SYNC_W-1:0] clk_sync_r; // Pin clock stages
  logic [`SYNC_W-1:0] ce_sync_r; // Clock enable stages
  logic [`SYNC_W-1:0] oe_sync_r; // Output enable stages
  bus_register_pkg::word_t data_s1_r; // First data stage
  bus_register_pkg::word_t data_s2_r; // Second data stage
  bus_register_pkg::word_t data_s3_r; // Third data stage

  // Three flops per control pin
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_sync_r <= `SYNC_CLR;
      // Enables start at their idle high level, so no false drive after reset
      ce_sync_r <= `SYNC_SET;
      oe_sync_r <= `SYNC_SET;
    end else begin
      clk_sync_r <= {clk_sync_r[`SYNC_W-2:0], pin_clk_i};
      ce_sync_r <= {ce_sync_r[`SYNC_W-2:0], ce_n_i};
      oe_sync_r <= {oe_sync_r[`SYNC_W-2:0], oe_n_i};
    end
  end

  // Three flops per data bit, same latency as the pin clock
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_s1_r <= `WORD_CLR;
      data_s2_r <= `WORD_CLR;
      data_s3_r <= `WORD_CLR;
    end else begin
      data_s1_r <= data_in_i;
      data_s2_r <= data_s1_r;
      data_s3_r <= data_s2_r;
    end
  end

  // ============================================================
  // Settled levels
  logic clk_lvl_r; // Settled pin clock
  logic clk_prev_r; // Pin clock one cycle earlier
  logic ce_lvl_r; // Settled clock enable, active low
  logic oe_lvl_r; // Settled output enable, active low
  bus_register_pkg::word_t data_lvl_r; // Settled data word
  bus_register_pkg::word_t agree; // Data bits whose last stages agree
  logic rise; // Rising edge of the pin clock
  logic load; // Qualified capture this cycle

  assign agree = ~(data_s2_r ^ data_s3_r);

  // Control levels, outputs start released
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_lvl_r <= 1'b0;
      clk_prev_r <= 1'b0;
      ce_lvl_r <= 1'b1;
      oe_lvl_r <= 1'b1;
    end else begin
      clk_lvl_r <= settle(clk_lvl_r, clk_sync_r[`SYNC_MID], clk_sync_r[`SYNC_LAST]);
      clk_prev_r <= clk_lvl_r;
      ce_lvl_r <= settle(ce_lvl_r, ce_sync_r[`SYNC_MID], ce_sync_r[`SYNC_LAST]);
      oe_lvl_r <= settle(oe_lvl_r, oe_sync_r[`SYNC_MID], oe_sync_r[`SYNC_LAST]);
    end
  end

  // Data level, bit by bit
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_lvl_r <= `WORD_CLR;
    end else begin
      data_lvl_r <= (data_s3_r & agree) | (data_lvl_r & ~agree);
    end
  end

  // Only a low-to-high move of the settled clock counts
  assign rise = clk_lvl_r & ~clk_prev_r;
  // Enable gates the edge; output enable plays no part
  assign load = rise & ~ce_lvl_r;

  // ============================================================
  // Storage
  bus_register_pkg::word_t store_r; // Twenty stored bits
  logic known_r; // Word has been loaded once

  // Word capture, held on every cycle without a load
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      store_r <= `WORD_CLR;
    end else if (load) begin
      store_r <= data_lvl_r;
    end
  end

  // Contents count as unknown until the first load
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      known_r <= 1'b0;
    end else if (load) begin
      known_r <= 1'b1;
    end
  end

  // ============================================================
  // Output drive
  // Stored word straight through, drive only while enabled
  assign data_out_o = store_r;
  assign data_out_oe_n_o = oe_lvl_r;
  assign word_known_o = known_r;

  // ============================================================
  // Capture stream
  logic buf_ready; // Buffer can take a word
  logic overrun_r; // A load found the buffer full

  two_entry_buf u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .in_valid_i(load),
    .in_ready_o(buf_ready),
    .in_data_i(data_lvl_r),
    .out_valid_o(cap_valid_o),
    .out_ready_i(cap_ready_i),
    .out_data_o(cap_data_o)
  );

  // Sticky flag for a word the stream could not keep
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      overrun_r <= 1'b0;
    end else if (load && !buf_ready) begin
      overrun_r <= 1'b1;
    end
  end

  assign cap_space_o = buf_ready;
  assign cap_overrun_o = overrun_r;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  // Load copies data without inversion
  noninv_out_a: assert property (load |=> data_out_o == $past(data_lvl_r))
    else $error("output differs from loaded word");

  // Pin edge with enable low reaches storage in five cycles
  pin_capture_a: assert property (
    (!clk_lvl_r && !ce_lvl_r && clk_sync_r[`SYNC_LAST] && clk_sync_r[`SYNC_MID])
    ##1 !ce_lvl_r |-> load)
    else $error("settled clock edge not loaded");

  // Enable high keeps word across an edge
  ce_hold_a: assert property (rise && ce_lvl_r |=> $stable(store_r))
    else $error("word changed with enable high");

  // No edge, no change
  idle_hold_a: assert property (!load |=> $stable(store_r) [*1])
    else $error("word changed without edge");

  // Released outputs while enable is high
  oe_release_a: assert property (oe_sync_r[`SYNC_LAST] && oe_sync_r[`SYNC_MID]
    |=> data_out_oe_n_o)
    else $error("outputs driven while disabled");

  // Loading unaffected by released outputs
  off_load_a: assert property (load && data_out_oe_n_o
    |=> store_r == $past(data_lvl_r) && known_r)
    else $error("load lost while outputs released");

  // Driven outputs show stored word
  oe_drive_a: assert property (!oe_lvl_r |-> !data_out_oe_n_o && data_out_o == store_r)
    else $error("enabled outputs not driving word");

  // Known flag rises only after a load
  known_first_a: assert property ($rose(word_known_o) |-> $past(load))
    else $error("word marked known without load");

endmodule

// ### test/stream_sink.sv
// Receiving bus logic model that drains the capture stream
module stream_sink (
  // Clock
  input wire logic clk_i,
  // Stream from the register
  input wire logic cap_valid_i,
  input wire bus_register_pkg::word_t cap_data_i,
  output logic cap_ready_o,
  // Stall request from the bench
  input wire logic stall_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Words taken, in arrival order
  bus_register_pkg::word_t got[$];
  // Ready level, defined from time zero
  logic ready_r = 1'b0;
  assign cap_ready_o = ready_r;
  // ============================================================
  // Take a word on each handshake edge; ready follows stall one edge later
  always @(posedge clk_i) begin
    if (cap_valid_i === 1'b1 && ready_r === 1'b1) begin
      got.push_back(cap_data_i);
    end
    ready_r <= !stall_i;
  end
endmodule

// ### test/bus_register_tb.sv
// Self-checking bench for the twenty-bit bus register
module bus_register_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ============================================================
  // Clock, reset and pins, all defined from time zero
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pin_clk_i = 1'b0;
  logic ce_n_i = 1'b1;
  logic oe_n_i = 1'b0;
  logic stall = 1'b0;
  bus_register_pkg::word_t data_in_i = 20'h00000;
  bus_register_pkg::word_t data_out_o;
  bus_register_pkg::word_t cap_data_o;
  logic data_out_oe_n_o;
  logic word_known_o;
  logic cap_valid_o;
  logic cap_ready_i;
  logic cap_space_o;
  logic cap_overrun_o;
  int n_errors = 0;
  int comparisons = 0;
  // Free-running system clock
  always #5 clk_i = ~clk_i;
  bus_register DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_clk_i(pin_clk_i),
    .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .data_in_i(data_in_i), .data_out_o(data_out_o),
    .data_out_oe_n_o(data_out_oe_n_o), .word_known_o(word_known_o),
    .cap_valid_o(cap_valid_o), .cap_ready_i(cap_ready_i), .cap_data_o(cap_data_o),
    .cap_space_o(cap_space_o), .cap_overrun_o(cap_overrun_o));
  stream_sink sink (.clk_i(clk_i), .cap_valid_i(cap_valid_o), .cap_data_i(cap_data_o),
    .cap_ready_o(cap_ready_i), .stall_i(stall));
  // ============================================================
  // Compare and count
  task automatic check(input bus_register_pkg::word_t seen, input bus_register_pkg::word_t exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait a number of falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // One pin clock pulse with data held around the rise
  task automatic load(input bus_register_pkg::word_t w, input logic ce);
    data_in_i = w;
    ce_n_i = ce;
    idle(4);
    pin_clk_i = 1'b1;
    idle(4);
    pin_clk_i = 1'b0;
    idle(6);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset;
    check(bus_register_pkg::word_t'(data_out_oe_n_o), 20'h00001);
    check(bus_register_pkg::word_t'(word_known_o), 20'h00000);
    check(bus_register_pkg::word_t'(cap_valid_o), 20'h00000);
    check(bus_register_pkg::word_t'(cap_space_o), 20'h00001);
    check(bus_register_pkg::word_t'(cap_overrun_o), 20'h00000);
  endtask
  task automatic t_load;
    load(20'hA5C3E, 1'b0);
    check(data_out_o, 20'hA5C3E);
    check(bus_register_pkg::word_t'(data_out_oe_n_o), 20'h00000);
    check(bus_register_pkg::word_t'(word_known_o), 20'h00001);
    check(sink.got[$], 20'hA5C3E);
  endtask
  task automatic t_ce_high;
    load(20'h5A3C1, 1'b1);
    check(data_out_o, 20'hA5C3E);
  endtask
  task automatic t_steady;
    ce_n_i = 1'b0;
    data_in_i = 20'hFFFFF;
    idle(8);
    check(data_out_o, 20'hA5C3E);
    ce_n_i = 1'b1;
    idle(4);
    pin_clk_i = 1'b1;
    idle(4);
    ce_n_i = 1'b0;
    data_in_i = 20'h00000;
    idle(8);
    check(data_out_o, 20'hA5C3E);
    ce_n_i = 1'b1;
    pin_clk_i = 1'b0;
    idle(6);
  endtask
  task automatic t_oe;
    oe_n_i = 1'b1;
    idle(6);
    check(bus_register_pkg::word_t'(data_out_oe_n_o), 20'h00001);
    load(20'h0F0F1, 1'b0);
    check(bus_register_pkg::word_t'(data_out_oe_n_o), 20'h00001);
    check(data_out_o, 20'h0F0F1);
    oe_n_i = 1'b0;
    idle(6);
    check(bus_register_pkg::word_t'(data_out_oe_n_o), 20'h00000);
    check(data_out_o, 20'h0F0F1);
  endtask
  task automatic t_buffer;
    stall = 1'b1;
    idle(4);
    sink.got.delete();
    load(20'h11111, 1'b0);
    load(20'h22222, 1'b0);
    check(bus_register_pkg::word_t'(cap_space_o), 20'h00000);
    load(20'h33333, 1'b0);
    check(data_out_o, 20'h33333);
    check(bus_register_pkg::word_t'(cap_overrun_o), 20'h00001);
    stall = 1'b0;
    idle(8);
    check(bus_register_pkg::word_t'(sink.got.size()), 20'h00002);
    check(sink.got[0], 20'h11111);
    check(sink.got[1], 20'h22222);
    check(bus_register_pkg::word_t'(cap_valid_o), 20'h00000);
  endtask
  // ============================================================
  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("comparisons %0d, n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog against a hung run
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    idle(10);
    t_reset();
    rst_n_i = 1'b1;
    idle(8);
    t_load();
    t_ce_high();
    t_steady();
    t_oe();
    t_buffer();
    give_verdict();
  end
endmodule
